// ===== port_queue_lookup_consts.vh
// register offsets, field positions, reset values and encodings for the port queue and lookup control block
`ifndef PORT_QUEUE_LOOKUP_CONSTS_VH
`define PORT_QUEUE_LOOKUP_CONSTS_VH
// register offsets within the port window (low 12 bits)
`define OFS_CONGESTION_DROP_CONTROL 12'ha00
`define OFS_FORWARD_MEMBERSHIP_MASK 12'ha04
`define OFS_TX_QUEUE_BLOCK_USAGE 12'ha10
`define OFS_LOOKUP_OPTIONS 12'hb00
// reset values
`define RST_CONGESTION_DROP_CONTROL 2'h0
`define RST_FORWARD_MEMBERSHIP_MASK 7'h7f
`define RST_LOOKUP_OPTIONS 8'h00
// drop mode encodings
`define DROP_MODE_NONE 2'h0
`define DROP_MODE_PRIO0 2'h1
`define DROP_MODE_PRIO1 2'h2
`define DROP_MODE_PRIO2 2'h3
// lookup option bit positions
`define BIT_NULL_VID_LOOKUP 7
`define BIT_INGRESS_VLAN_FILTER 6
`define BIT_DISCARD_NON_DEFAULT_VID 5
`define BIT_MAC_8021X 4
`define BIT_SELF_ADDR_FILTER 3
`define BIT_LOOKUP_RESERVED_RW 1
// writable mask of the lookup options register (bits 2 and 0 read-only zero)
`define LOOKUP_OPTIONS_WMASK 8'hfa
`endif

// ===== ingress_lookup_decide.v
// combinational ingress lookup decision for one received frame on this port
`include "port_queue_lookup_consts.vh"
module ingress_lookup_decide
#(
    parameter VID_W = 12,
    parameter NPORT = 7
)
(
    // lookup options from the register file
    input wire [7:0] options,
    input wire global_self_addr_en,
    input wire [VID_W-1:0] port_default_vlan_id,
    // frame attributes
    input wire frame_tagged,
    input wire [VID_W-1:0] frame_vid,
    input wire [47:0] frame_src_mac,
    input wire [47:0] switch_mac,
    input wire [NPORT-1:0] vlan_members,
    input wire [NPORT-1:0] ingress_port_onehot,
    // results
    output reg [VID_W-1:0] vlan_lookup_key,
    output reg discard,
    output wire mac_8021x_en
)
;
    // authentication choice is a plain level for the lookup engine
    assign mac_8021x_en = options[`BIT_MAC_8021X];

    // key selection and discard reasons
    always @*
    begin
        // null vid on a tagged frame: zero or the port default
        if (frame_tagged && frame_vid == {VID_W{1'b0}} && !options[`BIT_NULL_VID_LOOKUP])
        begin
            vlan_lookup_key = port_default_vlan_id;
        end
        else
        begin
            vlan_lookup_key = frame_vid;
        end
        discard = 1'b0;
        // ingress membership check
        if (options[`BIT_INGRESS_VLAN_FILTER] && ((vlan_members & ingress_port_onehot) == {NPORT{1'b0}}))
        begin
            discard = 1'b1;
        end
        // strict default vid match
        if (options[`BIT_DISCARD_NON_DEFAULT_VID] && frame_vid != port_default_vlan_id)
        begin
            discard = 1'b1;
        end
        // self-address only with both enables
        if (options[`BIT_SELF_ADDR_FILTER] && global_self_addr_en && frame_src_mac == switch_mac)
        begin
            discard = 1'b1;
        end
    end
endmodule

// ===== port_queue_lookup_control.v
// per-port queue management and address lookup control registers with their decisions
// What this block does
// - mode 00: no drop, flow control when congested
// - modes 01-11 drop low priorities, no flow control
// - seven-bit forward mask, reset ones, blocks ports
// - forward mask ignores vlan tags and table
// - read-only live eleven-bit transmit block count
// - null vid lookup key: zero or default
// - ingress vlan filter discards non-member frames
// - discard frames whose vid differs from default
// - bit enables mac based 802.1x authentication
// - drop frames whose source equals switch mac
// - self filtering needs port and global enables

// one copy of these registers per switch port; the switch repeats it per port
// register access is a plain strobe pair; reads answer one edge after the strobe
// every decision output lags its inputs by one clock so all outputs leave flops
// limitation: no byte lanes, every access moves a whole 32-bit word
`include "port_queue_lookup_consts.vh"
module port_queue_lookup_control
#(
    parameter NPORT = 7,
    parameter VID_W = 12,
    parameter TXQ_W = 11
)
(
    // clock and reset
    input wire CLK_SYS,
    input wire RESETN,
    // register access port, one word per access
    input wire REG_WR,
    input wire REG_RD,
    input wire [11:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    output reg [31:0] REG_RDATA,
    output reg REG_RVALID,
    // queue manager inputs
    input wire [TXQ_W-1:0] TX_QUEUE_BLOCK_COUNT,
    input wire DEST_CONGESTED,
    input wire [1:0] FRAME_PRIORITY,
    input wire [NPORT-1:0] FORWARD_CANDIDATES,
    // lookup inputs
    input wire GLOBAL_SELF_ADDR_EN,
    input wire [VID_W-1:0] PORT_DEFAULT_VLAN_ID,
    input wire FRAME_TAGGED,
    input wire [VID_W-1:0] FRAME_VID,
    input wire [47:0] FRAME_SRC_MAC,
    input wire [47:0] SWITCH_MAC,
    input wire [NPORT-1:0] VLAN_MEMBERS,
    input wire [NPORT-1:0] INGRESS_PORT_ONEHOT,
    // queue manager results
    output reg FLOW_CONTROL_REQ,
    output reg CONGESTION_DROP,
    output reg [NPORT-1:0] FORWARD_PORTS,
    // lookup results
    output reg [VID_W-1:0] VLAN_LOOKUP_KEY,
    output reg LOOKUP_DISCARD,
    output reg MAC_8021X_EN
)
;
    // software-visible state
    // reserved read-only option bits are forced to zero on every write
    reg [1:0] drop_mode_reg;
    reg [NPORT-1:0] fwd_mask_reg;
    reg [7:0] lookup_opts_reg;

    // decision wires from the lookup helper
    wire [VID_W-1:0] key_w;
    wire discard_w;
    wire dot1x_w;

    // drop threshold test: true when priority is at or below the mode cutoff
    // only consulted when a destination is congested
    function drop_hit;
        input [1:0] mode;
        input [1:0] prio;
        begin
            // 01 drops prio 0, 10 drops 0-1, 11 drops 0-2
            // the subtraction cannot wrap: mode 00 is ruled out first
            drop_hit = (mode != `DROP_MODE_NONE) && (prio <= mode - 2'h1);
        end
    endfunction

    // lookup decision logic kept separate so it can be reused per port
    // one helper instance; a multi-port build would repeat it
    ingress_lookup_decide #(
        .VID_W(VID_W),
        .NPORT(NPORT)
    ) u_decide (
        .options(lookup_opts_reg),
        // the global enable gates self filtering together with bit 3
        .global_self_addr_en(GLOBAL_SELF_ADDR_EN),
        .port_default_vlan_id(PORT_DEFAULT_VLAN_ID),
        .frame_tagged(FRAME_TAGGED),
        .frame_vid(FRAME_VID),
        .frame_src_mac(FRAME_SRC_MAC),
        .switch_mac(SWITCH_MAC),
        .vlan_members(VLAN_MEMBERS),
        .ingress_port_onehot(INGRESS_PORT_ONEHOT),
        // raw results, registered in the decision process below
        .vlan_lookup_key(key_w),
        .discard(discard_w),
        .mac_8021x_en(dot1x_w)
    );

    // register writes; unlisted and read-only addresses are ignored
    // a read one cycle after a write already sees the new value
    always @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            // power-on values of the writable fields
            drop_mode_reg <= `RST_CONGESTION_DROP_CONTROL;
            fwd_mask_reg <= `RST_FORWARD_MEMBERSHIP_MASK;
            lookup_opts_reg <= `RST_LOOKUP_OPTIONS;
        end
        else if (REG_WR)
        begin
            // address decoded on the low twelve bits only
            case (REG_ADDR)
                `OFS_CONGESTION_DROP_CONTROL:
                begin
                    // upper bits are reserved and dropped on write
                    drop_mode_reg <= REG_WDATA[1:0];
                end
                `OFS_FORWARD_MEMBERSHIP_MASK:
                begin
                    // bit k gates destination port k+1
                    fwd_mask_reg <= REG_WDATA[NPORT-1:0];
                end
                `OFS_LOOKUP_OPTIONS:
                begin
                    // bits 2 and 0 are read-only zero
                    lookup_opts_reg <= REG_WDATA[7:0] & `LOOKUP_OPTIONS_WMASK;
                end
                default:
                begin
                    // unmapped offsets land here as well
                    // block count register is read-only
                    drop_mode_reg <= drop_mode_reg;
                end
            endcase
        end
    end

    // read path, answered one cycle after the strobe
    // the count is passed straight through: a stored copy would lag a cycle
    always @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            REG_RDATA <= 32'h0000_0000;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            // valid follows the strobe by exactly one edge
            REG_RVALID <= REG_RD;
            if (REG_RD)
            begin
                // read data holds until the next read strobe
                case (REG_ADDR)
                    `OFS_CONGESTION_DROP_CONTROL:
                    begin
                        // drop mode sits in the low two bits
                        REG_RDATA <= {30'h0, drop_mode_reg};
                    end
                    `OFS_FORWARD_MEMBERSHIP_MASK:
                    begin
                        // reserved upper bits read as zero
                        REG_RDATA <= {{(32-NPORT){1'b0}}, fwd_mask_reg};
                    end
                    `OFS_TX_QUEUE_BLOCK_USAGE:
                    begin
                        // live value, not the one-cycle-old copy
                        REG_RDATA <= {{(32-TXQ_W){1'b0}}, TX_QUEUE_BLOCK_COUNT};
                    end
                    `OFS_LOOKUP_OPTIONS:
                    begin
                        // bits 2 and 0 are held at zero by the write path
                        REG_RDATA <= {24'h0, lookup_opts_reg};
                    end
                    default:
                    begin
                        // unmapped reads return zero
                        REG_RDATA <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // queue manager and lookup decisions, registered
    // registering here keeps every top-level output straight from a flop
    always @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            // nothing paused, dropped or forwarded during reset
            FLOW_CONTROL_REQ <= 1'b0;
            CONGESTION_DROP <= 1'b0;
            FORWARD_PORTS <= {NPORT{1'b0}};
            VLAN_LOOKUP_KEY <= {VID_W{1'b0}};
            LOOKUP_DISCARD <= 1'b0;
            MAC_8021X_EN <= 1'b0;
        end
        else
        begin
            // flow control only in the no-drop mode
            FLOW_CONTROL_REQ <= DEST_CONGESTED && (drop_mode_reg == `DROP_MODE_NONE);
            // drop only when congested and at or below the cutoff
            CONGESTION_DROP <= DEST_CONGESTED && drop_hit(drop_mode_reg, FRAME_PRIORITY);
            // mask applied with no regard to vlan state
            FORWARD_PORTS <= FORWARD_CANDIDATES & fwd_mask_reg;
            // lookup results trail the frame fields by one clock
            VLAN_LOOKUP_KEY <= key_w;
            LOOKUP_DISCARD <= discard_w;
            // 802.1x choice is a level for the lookup engine
            MAC_8021X_EN <= dot1x_w;
        end
    end
endmodule

// ===== port_queue_lookup_control_props.sv
// assertion checker for the port queue and lookup control block
`include "port_queue_lookup_consts.vh"
module pqlc_props #(parameter NPORT = 7, parameter VID_W = 12, parameter TXQ_W = 11)
(
    // single bit controls and results
    input wire CLK_SYS, RESETN, REG_RD, REG_RVALID, DEST_CONGESTED, FRAME_TAGGED, GLOBAL_SELF_ADDR_EN,
    input wire FLOW_CONTROL_REQ, CONGESTION_DROP, LOOKUP_DISCARD,
    // register read side
    input wire [11:0] REG_ADDR,
    input wire [31:0] REG_RDATA,
    // queue and lookup side
    input wire [1:0] FRAME_PRIORITY,
    input wire [TXQ_W-1:0] TX_QUEUE_BLOCK_COUNT,
    input wire [NPORT-1:0] FORWARD_CANDIDATES, VLAN_MEMBERS, INGRESS_PORT_ONEHOT, FORWARD_PORTS,
    input wire [VID_W-1:0] PORT_DEFAULT_VLAN_ID, FRAME_VID, VLAN_LOOKUP_KEY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    // high from the second edge after reset, so $past never sees reset-time inputs
    reg up_reg;
    always @(posedge CLK_SYS or negedge RESETN)
        if (!RESETN) up_reg <= 1'b0;
        else up_reg <= 1'b1;
    fc_drop_excl_a: assert property (!(FLOW_CONTROL_REQ && CONGESTION_DROP))
        else $error("pause and drop together");
    fc_cause_a: assert property (FLOW_CONTROL_REQ |-> $past(DEST_CONGESTED))
        else $error("pause without congestion");
    drop_cause_a: assert property (CONGESTION_DROP |-> $past(DEST_CONGESTED) && $past(FRAME_PRIORITY) != 2'h3)
        else $error("drop without cause");
    fwd_mask_a: assert property ((FORWARD_PORTS & ~$past(FORWARD_CANDIDATES)) == '0)
        else $error("forward beyond candidates");
    key_plain_a: assert property (up_reg && !($past(FRAME_TAGGED) && $past(FRAME_VID) == '0)
        |-> VLAN_LOOKUP_KEY == $past(FRAME_VID)) else $error("lookup key wrong");
    self_global_a: assert property (up_reg && !$past(GLOBAL_SELF_ADDR_EN)
        && $past(FRAME_VID) == $past(PORT_DEFAULT_VLAN_ID)
        && ($past(VLAN_MEMBERS) & $past(INGRESS_PORT_ONEHOT)) != '0 |-> !LOOKUP_DISCARD)
        else $error("bad discard");
    txq_read_a: assert property (REG_RVALID && $past(REG_ADDR) == `OFS_TX_QUEUE_BLOCK_USAGE
        |-> REG_RDATA == 32'($past(TX_QUEUE_BLOCK_COUNT))) else $error("block count read wrong");
    opt_resv_a: assert property (REG_RVALID && $past(REG_ADDR) == `OFS_LOOKUP_OPTIONS
        |-> (REG_RDATA & ~32'h000000fa) == 32'h0) else $error("reserved option bits set");
    cover property (CONGESTION_DROP);
    cover property (FLOW_CONTROL_REQ);
    cover property (LOOKUP_DISCARD);
endmodule
bind port_queue_lookup_control pqlc_props #(.NPORT(NPORT), .VID_W(VID_W), .TXQ_W(TXQ_W)) props_i (.*);

// ===== port_queue_lookup_control_test.sv
// self-checking bench for the port queue and lookup control block
module port_queue_lookup_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    // design inputs, all given a value at time zero
    logic CLK_SYS = 0, RESETN = 0, REG_WR = 0, REG_RD = 0, DEST_CONGESTED = 0, FRAME_TAGGED = 1;
    logic GLOBAL_SELF_ADDR_EN = 0;
    logic [11:0] REG_ADDR = 0, PORT_DEFAULT_VLAN_ID = 12'h123, FRAME_VID = 0;
    logic [31:0] REG_WDATA = 0;
    logic [10:0] TX_QUEUE_BLOCK_COUNT = 0;
    logic [1:0] FRAME_PRIORITY = 0;
    logic [6:0] FORWARD_CANDIDATES = 7'h7f, VLAN_MEMBERS = 7'h01, INGRESS_PORT_ONEHOT = 7'h01;
    logic [47:0] SWITCH_MAC = 48'h0a0b0c0d0e0f, FRAME_SRC_MAC = 0;
    // design outputs
    logic [31:0] REG_RDATA;
    logic REG_RVALID, FLOW_CONTROL_REQ, CONGESTION_DROP, LOOKUP_DISCARD, MAC_8021X_EN;
    logic [6:0] FORWARD_PORTS;
    logic [11:0] VLAN_LOOKUP_KEY;
    int errors = 0, compares = 0, cycles = 0;
    port_queue_lookup_control dut (.*);
    always #20 CLK_SYS = ~CLK_SYS;
    // hang guard, far above the hundred or so cycles the tests need
    always @(posedge CLK_SYS) if (++cycles == 3000) summarize(1);
    task automatic summarize(input int hung);
        errors += hung;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) $display("unexpected at %0t: saw %h wanted %h", $time, got, exp);
        errors += (got !== exp);
    endtask
    // inputs always move 1 ns after the edge
    task automatic tick();
        @(posedge CLK_SYS);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1;
        tick();
        REG_WR = 0;
        // idle edge so a following call never re-raises the strobe in one step
        tick();
    endtask
    // answer is registered, so it is looked at one edge after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        REG_ADDR = a;
        REG_RD = 1;
        tick();
        REG_RD = 0;
        chk(REG_RVALID, 1);
        chk(REG_RDATA, e);
        tick();
    endtask
    // reset values, read-only count and reserved bits
    task automatic t_regs();
        rd(12'ha00, 0);
        rd(12'ha04, 32'h7f);
        rd(12'ha10, 0);
        TX_QUEUE_BLOCK_COUNT = 11'h7ff;
        wr(12'ha10, 0);
        rd(12'ha10, 32'h7ff);
        wr(12'hb00, 32'hffffffff);
        rd(12'hb00, 32'hfa);
        rd(12'ha08, 0);
    endtask
    // every drop mode against every priority, then congestion gone
    task automatic t_drop();
        for (int m = 0; m < 4; m++)
        begin
            wr(12'ha00, 32'hfffffffc | m);
            rd(12'ha00, m);
            DEST_CONGESTED = 1;
            for (int p = 0; p < 4; p++)
            begin
                FRAME_PRIORITY = p;
                tick();
                chk(FLOW_CONTROL_REQ, m == 0);
                chk(CONGESTION_DROP, m != 0 && p < m);
            end
            DEST_CONGESTED = 0;
            tick();
            chk({FLOW_CONTROL_REQ, CONGESTION_DROP}, 0);
        end
    endtask
    // mask applies with the vlan table saying nothing
    task automatic t_fwd();
        VLAN_MEMBERS = 7'h00;
        wr(12'ha04, 32'hffffff05);
        rd(12'ha04, 32'h05);
        chk(FORWARD_PORTS, 7'h05);
        wr(12'ha04, 32'h7e);
        FORWARD_CANDIDATES = 7'h41;
        tick();
        chk(FORWARD_PORTS, 7'h40);
        VLAN_MEMBERS = 7'h01;
    endtask
    task automatic look(input logic [7:0] o, input logic [11:0] v, input logic [6:0] m, input logic g, s, d);
        wr(12'hb00, o);
        FRAME_VID = v;
        VLAN_MEMBERS = m;
        GLOBAL_SELF_ADDR_EN = g;
        FRAME_SRC_MAC = s ? SWITCH_MAC : ~SWITCH_MAC;
        tick();
        chk(LOOKUP_DISCARD, d);
    endtask
    // lookup key, filters and self-address drop
    task automatic t_look();
        look(8'h80, 0, 1, 0, 0, 0);
        chk(VLAN_LOOKUP_KEY, 0);
        look(8'h00, 0, 1, 0, 0, 0);
        chk(VLAN_LOOKUP_KEY, 12'h123);
        FRAME_TAGGED = 0;
        look(8'h00, 0, 1, 0, 0, 0);
        chk(VLAN_LOOKUP_KEY, 0);
        FRAME_TAGGED = 1;
        chk(MAC_8021X_EN, 0);
        look(8'h10, 12'h123, 1, 0, 0, 0);
        chk(MAC_8021X_EN, 1);
        look(8'h40, 12'h123, 0, 0, 0, 1);
        look(8'h40, 12'h123, 1, 0, 0, 0);
        look(8'h00, 12'h123, 0, 1, 1, 0);
        look(8'h20, 12'h124, 1, 0, 0, 1);
        look(8'h20, 12'h123, 1, 0, 0, 0);
        look(8'h08, 12'h123, 1, 0, 1, 0);
        look(8'h08, 12'h123, 1, 1, 1, 1);
        look(8'h08, 12'h123, 1, 1, 0, 0);
    endtask
    // reset in mid-run brings the forward mask back to all ones
    task automatic t_rst();
        wr(12'ha04, 32'h0);
        chk(FORWARD_PORTS, 0);
        RESETN = 0;
        tick();
        RESETN = 1;
        rd(12'ha04, 32'h7f);
        chk(FORWARD_PORTS, 7'h41);
    endtask
    initial
    begin
        repeat (10) @(posedge CLK_SYS);
        #1 RESETN = 1;
        t_regs();
        t_drop();
        t_fwd();
        t_look();
        t_rst();
        summarize(0);
    end
endmodule
